// >>> rtl/tx_cfg_pkg.sv
package tx_cfg_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_DRIVER_PIN_MODE     = 8'h28;
    localparam logic [7:0] IDX_CARRIER_AMPLITUDE   = 8'h29;
    localparam logic [7:0] IDX_TRANSMIT_CONTROL    = 8'h2a;
    localparam logic [7:0] IDX_DRIVER_LOAD_OVERSH  = 8'h2b;
    localparam logic [7:0] IDX_TRANSMIT_CRC_SETUP  = 8'h2c;
    localparam logic [7:0] IDX_TX_STATUS           = 8'h30;
    localparam logic [7:0] IDX_CRC_VALUE_LO        = 8'h31;
    localparam logic [7:0] IDX_CRC_VALUE_HI        = 8'h32;
    localparam int         ADDR_W                  = 10;

    // ==========================================================
    // reset values and writable bit masks
    localparam logic [7:0] RST_REG                 = 8'h00;
    localparam logic [7:0] MASK_DRIVER_PIN_MODE    = 8'hcf;
    localparam logic [7:0] MASK_CARRIER_AMPLITUDE  = 8'hdf;
    localparam logic [7:0] MASK_TRANSMIT_CRC_SETUP = 8'h7f;

    // ==========================================================
    // driver output style codes
    typedef enum logic [2:0] {
        STYLE_OPEN_DRAIN = 3'b000,
        STYLE_PUSH_PULL  = 3'b001,
        STYLE_HIGH_Z     = 3'b010,
        STYLE_BAD_A      = 3'b011,
        STYLE_FORCE_LOW  = 3'b100,
        STYLE_FORCE_HIGH = 3'b101,
        STYLE_BAD_B      = 3'b110,
        STYLE_SPARE      = 3'b111
    } drive_style_e;

    typedef enum logic [1:0] {
        MOD_NONE     = 2'b00,
        MOD_ENVELOPE = 2'b01,
        MOD_EXTERNAL = 2'b10,
        MOD_RESERVED = 2'b11
    } mod_source_e;

    typedef enum logic [1:0] {
        CRC_5        = 2'b00,
        CRC_8        = 2'b01,
        CRC_16       = 2'b10,
        CRC_RESERVED = 2'b11
    } crc_kind_e;

    // ==========================================================
    // crc polynomials, bit reversed for lsb-first shifting
    localparam logic [15:0] POLY_CRC16 = 16'h8408;
    localparam logic [15:0] POLY_CRC8  = 16'h00b8;
    localparam logic [15:0] POLY_CRC5  = 16'h0012;
    localparam logic [15:0] MASK_CRC16 = 16'hffff;
    localparam logic [15:0] MASK_CRC8  = 16'h00ff;
    localparam logic [15:0] MASK_CRC5  = 16'h001f;

    // ==========================================================
    // decoded register fields
    typedef struct packed {
        logic         invert_b;
        logic         invert_a;
        logic         pins_enable;
        drive_style_e style;
    } drv_cfg_s;

    typedef struct packed {
        logic [2:0] start_sel;
        crc_kind_e  kind;
        logic       complement;
        logic       append_on;
    } crc_cfg_s;

endpackage

// >>> rtl/tx_driver_and_crc_config.sv
// Function
// - bit 7 of pin mode inverts the second antenna driver pin
// - bit 6 of pin mode inverts the first antenna driver pin
// - both driver pins are enabled only while bit 3 is one
// - three-bit output style field; codes 011b and 110b must not be used
// - amplitude bits 7:6 pick a reduction of 100, 250, 500 or 1000 mV
// - maximum-carrier bit gives full amplitude, overriding the reduction field
// - amplitude bits 4:0 hold residual carrier percentage; bit 5 reserved
// - control bits 7:4 give extra anti-overshoot modulation length in carrier periods
// - control bit 2 inverts the selected modulation signal
// - source select: none, internal envelope, external serial input; 11b reserved
// - load register bits 7:4 hold first overshoot timer value
// - load register bits 3:0 hold trimmed load current steering modulation index
// - crc setup bits 6:4 pick generator start value; bit 7 reserved
// - crc setup bits 3:2 pick five, eight or sixteen bit crc
// - crc complement bit appends the inverted crc
// - crc append bit appends the crc; clear means none
// - start codes 0,1,2,3,7 map to the fixed start values per crc width; for five-bit crc codes 2 and 3 define none
// - start code 6 loads the stored user value; others define none
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module tx_driver_and_crc_config
    import tx_cfg_pkg::*;
(
    // clock and reset
    input  wire  logic              CLK,
    input  wire  logic              SYS_RST,
    // avalon-mm slave
    input  wire  logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire  logic              AVS_READ,
    input  wire  logic              AVS_WRITE,
    input  wire  logic [3:0]        AVS_BYTEENABLE,
    input  wire  logic [31:0]       AVS_WRITEDATA,
    output logic       [31:0]       AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    // carrier and modulation sources
    input  wire  logic              CARRIER_IN,
    input  wire  logic              CARRIER_TICK,
    input  wire  logic              INTERNAL_ENVELOPE,
    input  wire  logic              EXTERNAL_SERIAL_INPUT,
    // crc data stream
    input  wire  logic              FRAME_START,
    input  wire  logic              CRC_BIT_VALID,
    input  wire  logic              CRC_BIT,
    input  wire  logic [15:0]       USER_CRC_START,
    // antenna driver pins
    output logic                    ANTENNA_DRIVER_A_O,
    output logic                    ANTENNA_DRIVER_A_OE_N,
    output logic                    ANTENNA_DRIVER_B_O,
    output logic                    ANTENNA_DRIVER_B_OE_N,
    // analog steering
    output logic                    MOD_ACTIVE,
    output logic                    OVERSHOOT_BOOST,
    output logic                    CARRIER_FULL,
    output logic       [1:0]        CARRIER_LEVEL_REDUCTION,
    output logic       [4:0]        RESIDUAL_CARRIER,
    output logic       [3:0]        EXPECTED_LOAD_CURRENT_TRIM,
    // crc result
    output logic       [15:0]       CRC_APPEND_VALUE,
    output logic                    CRC_APPEND_ON
);

    // ==========================================================
    // registers
    logic [7:0]  driver_pin_mode_ff;
    logic [7:0]  carrier_amplitude_ff;
    logic [7:0]  transmit_control_ff;
    logic [7:0]  driver_load_overshoot_ff;
    logic [7:0]  transmit_crc_setup_ff;
    logic        wait_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  index;
    logic        wr_go;
    logic        lane0;
    drv_cfg_s    drv;
    crc_cfg_s    crc_cfg;
    mod_source_e mod_sel;

    assign index   = AVS_ADDRESS[ADDR_W-1:2];
    assign lane0   = AVS_BYTEENABLE[0] && (AVS_ADDRESS[1:0] == 2'b00);
    assign wr_go   = AVS_WRITE && !wait_ff && lane0;
    assign drv     = drv_cfg_s'({driver_pin_mode_ff[7:6], driver_pin_mode_ff[3:0]});
    assign crc_cfg = crc_cfg_s'(transmit_crc_setup_ff[6:0]);
    assign mod_sel = mod_source_e'(transmit_control_ff[1:0]);

    // ==========================================================
    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wait_ff <= 1'b1;
        end else if ((AVS_READ || AVS_WRITE) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // ==========================================================
    // register writes, reserved bits held at zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            driver_pin_mode_ff       <= RST_REG;
            carrier_amplitude_ff     <= RST_REG;
            transmit_control_ff      <= RST_REG;
            driver_load_overshoot_ff <= RST_REG;
            transmit_crc_setup_ff    <= RST_REG;
        end else if (wr_go) begin
            case (index)
                IDX_DRIVER_PIN_MODE:
                    driver_pin_mode_ff <= AVS_WRITEDATA[7:0] & MASK_DRIVER_PIN_MODE;
                IDX_CARRIER_AMPLITUDE:
                    carrier_amplitude_ff <= AVS_WRITEDATA[7:0] & MASK_CARRIER_AMPLITUDE;
                IDX_TRANSMIT_CONTROL:   transmit_control_ff <= AVS_WRITEDATA[7:0];
                IDX_DRIVER_LOAD_OVERSH: driver_load_overshoot_ff <= AVS_WRITEDATA[7:0];
                IDX_TRANSMIT_CRC_SETUP:
                    transmit_crc_setup_ff <= AVS_WRITEDATA[7:0] & MASK_TRANSMIT_CRC_SETUP;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // modulation source, inversion and overshoot timing
    logic       sig_meta_ff;
    logic       sig_sync_ff;
    logic       mod_raw;
    logic       mod_sel_ff;
    logic       nxt_mod_sel;
    logic [3:0] os_first_ff;
    logic [3:0] os_second_ff;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sig_meta_ff <= 1'b0;
            sig_sync_ff <= 1'b0;
        end else begin
            sig_meta_ff <= EXTERNAL_SERIAL_INPUT;
            sig_sync_ff <= sig_meta_ff;
        end
    end

    always_comb begin
        case (mod_sel)
            MOD_ENVELOPE: mod_raw = INTERNAL_ENVELOPE;
            MOD_EXTERNAL: mod_raw = sig_sync_ff;
            default:      mod_raw = 1'b0;
        endcase
    end

    assign nxt_mod_sel = mod_raw ^ transmit_control_ff[2];

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mod_sel_ff <= 1'b0;
        end else begin
            mod_sel_ff <= nxt_mod_sel;
        end
    end

    // first timer boosts after a rising edge, second extends after a falling one
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            os_first_ff  <= 4'h0;
            os_second_ff <= 4'h0;
        end else begin
            if (nxt_mod_sel && !mod_sel_ff) begin
                os_first_ff <= driver_load_overshoot_ff[7:4];
            end else if (CARRIER_TICK && os_first_ff != 4'h0) begin
                os_first_ff <= os_first_ff - 4'h1;
            end
            if (mod_sel_ff && !nxt_mod_sel) begin
                os_second_ff <= transmit_control_ff[7:4];
            end else if (mod_sel_ff) begin
                os_second_ff <= 4'h0;
            end else if (CARRIER_TICK && os_second_ff != 4'h0) begin
                os_second_ff <= os_second_ff - 4'h1;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MOD_ACTIVE      <= 1'b0;
            OVERSHOOT_BOOST <= 1'b0;
        end else begin
            MOD_ACTIVE      <= mod_sel_ff || (os_second_ff != 4'h0);
            OVERSHOOT_BOOST <= mod_sel_ff && (os_first_ff != 4'h0);
        end
    end

    // ==========================================================
    // antenna driver pins
    logic [1:0] pin_level;
    logic [1:0] pin_oe_n;
    logic [1:0] pin_inv;

    assign pin_inv = {drv.invert_b, drv.invert_a};

    for (genvar p = 0; p < 2; p++) begin : g_pin
        always_comb begin
            pin_level[p] = CARRIER_IN ^ pin_inv[p];
            pin_oe_n[p]  = 1'b1;
            case (drv.style)
                STYLE_OPEN_DRAIN: pin_oe_n[p] = pin_level[p];
                STYLE_PUSH_PULL:  pin_oe_n[p] = 1'b0;
                STYLE_FORCE_LOW: begin
                    pin_level[p] = 1'b0;
                    pin_oe_n[p]  = 1'b0;
                end
                STYLE_FORCE_HIGH: begin
                    pin_level[p] = 1'b1;
                    pin_oe_n[p]  = 1'b0;
                end
                default:          pin_oe_n[p] = 1'b1;
            endcase
            if (!drv.pins_enable) begin
                pin_oe_n[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ANTENNA_DRIVER_A_O    <= 1'b0;
            ANTENNA_DRIVER_A_OE_N <= 1'b1;
            ANTENNA_DRIVER_B_O    <= 1'b0;
            ANTENNA_DRIVER_B_OE_N <= 1'b1;
        end else begin
            ANTENNA_DRIVER_A_O    <= pin_level[0];
            ANTENNA_DRIVER_A_OE_N <= pin_oe_n[0];
            ANTENNA_DRIVER_B_O    <= pin_level[1];
            ANTENNA_DRIVER_B_OE_N <= pin_oe_n[1];
        end
    end

    // ==========================================================
    // amplitude and load steering
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CARRIER_FULL               <= 1'b0;
            CARRIER_LEVEL_REDUCTION    <= 2'b00;
            RESIDUAL_CARRIER           <= 5'h00;
            EXPECTED_LOAD_CURRENT_TRIM <= 4'h0;
        end else begin
            CARRIER_FULL               <= transmit_control_ff[3];
            CARRIER_LEVEL_REDUCTION    <= transmit_control_ff[3] ?
                                          2'b00 : carrier_amplitude_ff[7:6];
            RESIDUAL_CARRIER           <= carrier_amplitude_ff[4:0];
            EXPECTED_LOAD_CURRENT_TRIM <= driver_load_overshoot_ff[3:0];
        end
    end

    // ==========================================================
    // crc start value, polynomial and generator
    logic [15:0] crc_start;
    logic        start_undef;
    logic [15:0] poly;
    logic [15:0] crc_mask;
    logic [15:0] crc_ff;
    logic        fb;

    always_comb begin
        crc_start   = 16'h0000;
        start_undef = 1'b0;
        case (crc_cfg.start_sel)
            3'h0: crc_start = 16'h0000;
            3'h1: crc_start = (crc_cfg.kind == CRC_16) ? 16'h6363 : 16'h0012;
            3'h2: begin
                crc_start   = (crc_cfg.kind == CRC_16) ? 16'ha671 : 16'h00bf;
                start_undef = (crc_cfg.kind == CRC_5);
            end
            3'h3: begin
                crc_start   = (crc_cfg.kind == CRC_16) ? 16'hfffe : 16'h00fd;
                start_undef = (crc_cfg.kind == CRC_5);
            end
            3'h6: crc_start = USER_CRC_START;
            3'h7: crc_start = 16'hffff;
            default: start_undef = 1'b1;
        endcase
        if (start_undef) begin
            crc_start = 16'h0000;
        end
    end

    always_comb begin
        case (crc_cfg.kind)
            CRC_5: begin
                poly     = POLY_CRC5;
                crc_mask = MASK_CRC5;
            end
            CRC_8: begin
                poly     = POLY_CRC8;
                crc_mask = MASK_CRC8;
            end
            CRC_16: begin
                poly     = POLY_CRC16;
                crc_mask = MASK_CRC16;
            end
            default: begin
                poly     = 16'h0000;
                crc_mask = 16'h0000;
            end
        endcase
    end

    assign fb = crc_ff[0] ^ CRC_BIT;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            crc_ff <= 16'h0000;
        end else if (FRAME_START) begin
            crc_ff <= crc_start & crc_mask;
        end else if (CRC_BIT_VALID && crc_cfg.kind != CRC_RESERVED) begin
            crc_ff <= ({1'b0, crc_ff[15:1]} ^ (fb ? poly : 16'h0000)) & crc_mask;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CRC_APPEND_VALUE <= 16'h0000;
            CRC_APPEND_ON    <= 1'b0;
        end else begin
            CRC_APPEND_VALUE <= crc_cfg.complement ?
                                (~crc_ff & crc_mask) : crc_ff;
            CRC_APPEND_ON    <= crc_cfg.append_on;
        end
    end

    // ==========================================================
    // register reads
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_ff <= 8'h00;
        end else if (AVS_READ && wait_ff) begin
            case (index)
                IDX_DRIVER_PIN_MODE:    rdata_ff <= driver_pin_mode_ff;
                IDX_CARRIER_AMPLITUDE:  rdata_ff <= carrier_amplitude_ff;
                IDX_TRANSMIT_CONTROL:   rdata_ff <= transmit_control_ff;
                IDX_DRIVER_LOAD_OVERSH: rdata_ff <= driver_load_overshoot_ff;
                IDX_TRANSMIT_CRC_SETUP: rdata_ff <= transmit_crc_setup_ff;
                IDX_TX_STATUS:          rdata_ff <= {3'b000,
                                            crc_cfg.kind == CRC_RESERVED,
                                            drv.style == STYLE_BAD_A || drv.style == STYLE_BAD_B,
                                            start_undef, OVERSHOOT_BOOST, MOD_ACTIVE};
                IDX_CRC_VALUE_LO:       rdata_ff <= crc_ff[7:0];
                IDX_CRC_VALUE_HI:       rdata_ff <= crc_ff[15:8];
                default:                rdata_ff <= 8'h00;
            endcase
        end
    end

    assign AVS_READDATA    = {24'h000000, rdata_ff};
    assign AVS_WAITREQUEST = wait_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_pin_b_invert: assert property (drv.pins_enable && drv.style == STYLE_PUSH_PULL
        |=> ANTENNA_DRIVER_B_O == ($past(CARRIER_IN) ^ $past(drv.invert_b)))
        else $error("second driver level wrong");
    a_pin_a_invert: assert property (drv.pins_enable && drv.style == STYLE_PUSH_PULL
        |=> ANTENNA_DRIVER_A_O == ($past(CARRIER_IN) ^ $past(drv.invert_a)))
        else $error("first driver level wrong");
    a_pins_off_disabled: assert property (!driver_pin_mode_ff[3]
        |=> ANTENNA_DRIVER_A_OE_N && ANTENNA_DRIVER_B_OE_N)
        else $error("driver pin enabled while off");
    a_style_high_z: assert property (drv.style == STYLE_HIGH_Z
        |=> ANTENNA_DRIVER_A_OE_N && ANTENNA_DRIVER_B_OE_N)
        else $error("driver not released in high impedance");
    a_full_carrier: assert property (transmit_control_ff[3]
        |=> CARRIER_FULL && CARRIER_LEVEL_REDUCTION == 2'b00)
        else $error("full carrier not applied");
    a_mod_invert: assert property (mod_sel == MOD_ENVELOPE
        |=> mod_sel_ff == ($past(INTERNAL_ENVELOPE) ^ $past(transmit_control_ff[2])))
        else $error("modulation inversion wrong");
    a_no_mod_source: assert property (mod_sel == MOD_NONE && !transmit_control_ff[2]
        |=> !mod_sel_ff)
        else $error("modulation without source");
    a_second_os_len: assert property (mod_sel_ff && !nxt_mod_sel
        && transmit_control_ff[7:4] != 4'h0 |=> MOD_ACTIVE ##1 MOD_ACTIVE)
        else $error("overshoot extension missing");
    a_first_os_boost: assert property (!mod_sel_ff && nxt_mod_sel
        && driver_load_overshoot_ff[7:4] != 4'h0 |=> ##1 OVERSHOOT_BOOST)
        else $error("first overshoot timer missing");
    a_crc_reload: assert property (FRAME_START
        |=> crc_ff == ($past(crc_start) & $past(crc_mask)))
        else $error("crc start value not loaded");
    a_crc_complement: assert property (crc_cfg.complement && crc_cfg.kind == CRC_16
        |=> CRC_APPEND_VALUE == ~$past(crc_ff))
        else $error("crc not complemented");
    a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");

endmodule

// >>> tb/tx_driver_and_crc_config_tb.sv
`timescale 1ns/1ps
module tx_driver_and_crc_config_tb;
    import tx_cfg_pkg::*;
    // ==========================================================
    // clock, reset and design signals
    logic CLK = 1'b0, SYS_RST = 1'b1;
    logic [ADDR_W-1:0] AVS_ADDRESS = '0;
    logic AVS_READ = 0, AVS_WRITE = 0;
    logic [3:0] AVS_BYTEENABLE = 4'h1;
    logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA;
    logic AVS_WAITREQUEST, CARRIER_IN = 1, CARRIER_TICK = 1, INTERNAL_ENVELOPE = 0;
    logic EXTERNAL_SERIAL_INPUT = 0, FRAME_START = 0, CRC_BIT_VALID = 0, CRC_BIT = 0;
    logic [15:0] USER_CRC_START = 16'h5a3c, CRC_APPEND_VALUE;
    logic A_O, A_OE_N, B_O, B_OE_N, MOD_ACTIVE, OVERSHOOT_BOOST, CARRIER_FULL, CRC_APPEND_ON;
    logic [1:0] LVL;
    logic [4:0] RESID;
    logic [3:0] TRIM;
    int num_errors = 0, num_checks = 0;
    logic [7:0] q;
    always #2 CLK = ~CLK;

    tx_driver_and_crc_config u_dut (.CLK(CLK), .SYS_RST(SYS_RST),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .CARRIER_IN(CARRIER_IN), .CARRIER_TICK(CARRIER_TICK),
        .INTERNAL_ENVELOPE(INTERNAL_ENVELOPE), .EXTERNAL_SERIAL_INPUT(EXTERNAL_SERIAL_INPUT),
        .FRAME_START(FRAME_START), .CRC_BIT_VALID(CRC_BIT_VALID), .CRC_BIT(CRC_BIT),
        .USER_CRC_START(USER_CRC_START), .ANTENNA_DRIVER_A_O(A_O),
        .ANTENNA_DRIVER_A_OE_N(A_OE_N), .ANTENNA_DRIVER_B_O(B_O),
        .ANTENNA_DRIVER_B_OE_N(B_OE_N), .MOD_ACTIVE(MOD_ACTIVE),
        .OVERSHOOT_BOOST(OVERSHOOT_BOOST), .CARRIER_FULL(CARRIER_FULL),
        .CARRIER_LEVEL_REDUCTION(LVL), .RESIDUAL_CARRIER(RESID),
        .EXPECTED_LOAD_CURRENT_TRIM(TRIM), .CRC_APPEND_VALUE(CRC_APPEND_VALUE),
        .CRC_APPEND_ON(CRC_APPEND_ON));

    // ==========================================================
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int i;
        @(posedge CLK);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge CLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        if (i == 20) begin
            num_errors++;
            report_and_stop();
        end
        q = AVS_READDATA[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] idx[5] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
        logic [7:0] msk[5] = '{8'hcf, 8'hdf, 8'hff, 8'hff, 8'h7f};
        for (int k = 0; k < 5; k++) begin
            bus(1'b0, idx[k], 8'h00);
            chk(q, 8'h00, "reset value");
            bus(1'b1, idx[k], 8'hff);
            bus(1'b0, idx[k], 8'h00);
            chk(q, msk[k], "writable bits");
        end
        bus(1'b1, 8'h40, 8'hff);
        bus(1'b0, 8'h40, 8'h00);
        chk(q, 8'h00, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_pins();
        bus(1'b1, 8'h2a, 8'h00);
        bus(1'b1, 8'h28, 8'h09); step(3);
        chk({A_OE_N, B_OE_N, A_O, B_O}, 4'h3, "pins enabled");
        bus(1'b1, 8'h28, 8'h49); step(3);
        chk({A_O, B_O}, 2'b01, "first inverted");
        bus(1'b1, 8'h28, 8'h89); step(3);
        chk({A_O, B_O}, 2'b10, "second inverted");
        bus(1'b1, 8'h28, 8'h01); step(3);
        chk({A_OE_N, B_OE_N}, 2'b11, "pins disabled");
        bus(1'b1, 8'h28, 8'h0a); step(3);
        chk({A_OE_N, B_OE_N}, 2'b11, "high impedance");
        bus(1'b1, 8'h28, 8'h0b); step(3);
        chk({A_OE_N, B_OE_N}, 2'b11, "unsupported style");
        bus(1'b1, 8'h28, 8'h48); step(3);
        chk({A_OE_N, B_OE_N}, 2'b01, "open drain");
        bus(1'b1, 8'h28, 8'h0c); step(3);
        chk({A_OE_N, B_OE_N, A_O, B_O}, 4'h0, "force low");
        bus(1'b1, 8'h28, 8'h0d); step(3);
        chk({A_OE_N, B_OE_N, A_O, B_O}, 4'h3, "force high");
        $display("test pins done");
    endtask
    task automatic t_amp();
        bus(1'b1, 8'h29, 8'h95);
        bus(1'b1, 8'h2b, 8'ha7); step(3);
        chk({CARRIER_FULL, LVL, RESID}, {1'b0, 2'h2, 5'h15}, "amplitude");
        chk(TRIM, 4'h7, "load trim");
        bus(1'b1, 8'h2a, 8'h08); step(3);
        chk({CARRIER_FULL, LVL}, 3'b100, "max carrier");
        $display("test amplitude done");
    endtask
    task automatic t_mod();
        bus(1'b1, 8'h2b, 8'h27);
        bus(1'b1, 8'h2a, 8'h01);
        INTERNAL_ENVELOPE <= 1'b1; step(3);
        chk(MOD_ACTIVE, 1'b1, "envelope source");
        chk(OVERSHOOT_BOOST, 1'b1, "first overshoot timer");
        INTERNAL_ENVELOPE <= 1'b0; step(3);
        chk(MOD_ACTIVE, 1'b0, "envelope off");
        chk(OVERSHOOT_BOOST, 1'b0, "first timer ended");
        bus(1'b1, 8'h2a, 8'h05); step(3);
        chk(MOD_ACTIVE, 1'b1, "inverted source");
        bus(1'b1, 8'h2a, 8'h02);
        EXTERNAL_SERIAL_INPUT <= 1'b1; step(5);
        chk(MOD_ACTIVE, 1'b1, "external source");
        bus(1'b1, 8'h2a, 8'h00); step(3);
        chk(MOD_ACTIVE, 1'b0, "no modulation");
        EXTERNAL_SERIAL_INPUT <= 1'b0;
        bus(1'b1, 8'h2a, 8'h31);
        INTERNAL_ENVELOPE <= 1'b1; step(4);
        INTERNAL_ENVELOPE <= 1'b0; step(3);
        chk(MOD_ACTIVE, 1'b1, "overshoot extension");
        step(2);
        chk(MOD_ACTIVE, 1'b1, "extension last cycle");
        step(1);
        chk(MOD_ACTIVE, 1'b0, "extension ended");
        $display("test modulation done");
    endtask
    task automatic crc(input logic [7:0] cfg, input logic [15:0] exp, input logic on);
        bus(1'b1, 8'h2c, cfg);
        CRC_BIT_VALID <= 1'b1;
        CRC_BIT <= 1'b1;
        step(1);
        CRC_BIT_VALID <= 1'b0;
        FRAME_START <= 1'b1;
        step(1);
        FRAME_START <= 1'b0;
        step(3);
        chk(CRC_APPEND_VALUE, exp, "crc start value");
        chk(CRC_APPEND_ON, on, "crc append");
    endtask
    task automatic t_crc();
        logic [2:0] code[5] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd7};
        logic [15:0] v16[5] = '{16'h0000, 16'h6363, 16'ha671, 16'hfffe, 16'hffff};
        for (int k = 0; k < 5; k++) crc({1'b0, code[k], 4'b1001}, v16[k], 1'b1);
        crc(8'h69, USER_CRC_START, 1'b1);
        crc(8'h48, 16'h0000, 1'b0);
        crc(8'h27, 16'h0040, 1'b1);
        crc(8'h71, 16'h001f, 1'b1);
        $display("test crc done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        step(6);
        SYS_RST <= 1'b0;
        t_regs();
        t_pins();
        t_amp();
        t_mod();
        t_crc();
        report_and_stop();
    end
    initial begin
        step(20000);
        num_errors++;
        report_and_stop();
    end
endmodule
